// ==== logic/fss_pkg.sv ====
// constants, types and state codes for the fill-and-spill self-test sequencer
// Operation
// - In self-test the pixels receive electrically injected charge instead of photon charge.
// - An on-chip controller ties injection to the CCD sequence; the shutter governs acquisition, flush and shift as usual.
// - The frame-available flag rises when the internal shift completes, as in illuminated operation.
// - After the unlock writes the test registers stay writable until the next reset.
// - Pattern register 0xD3: bit 6 odd pixels, bit 5 pixels 2,6,10.., bit 4 pixels 4,12,20.., bit 3 pixels 0,8,16.., bit 7 unused.
// - The analog test pins are outputs by default; no stimulus may be driven before self-test mode.
// - The test registers are reached through the device's register write interface shared with analog overrides.
package fss_pkg;

	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [7:0] ADDR_KEY_A     = 8'hD0;
	localparam logic [7:0] ADDR_KEY_B     = 8'hD1;
	localparam logic [7:0] ADDR_PRIMARY   = 8'hD2;
	localparam logic [7:0] ADDR_PATTERN   = 8'hD3;
	localparam logic [7:0] ADDR_SECONDARY = 8'hD4;
	localparam logic [7:0] ADDR_TERTIARY  = 8'hD5;

	localparam logic [7:0] KEY_A_VAL      = 8'h4A;
	localparam logic [7:0] KEY_B_VAL      = 8'h66;
	localparam logic [7:0] PRIMARY_ON     = 8'h02;
	localparam logic [7:0] SECONDARY_ON   = 8'h20;
	localparam logic [7:0] TERTIARY_ON    = 8'h21;

	localparam logic [7:0] PRIMARY_RST    = 8'h00;
	localparam logic [7:0] PATTERN_RST    = 8'h00;
	localparam logic [7:0] SECONDARY_RST  = 8'h00;
	localparam logic [7:0] TERTIARY_RST   = 8'h01;

	// unlock sequence, entry 0 first
	localparam int         UNLOCK_STEPS   = 5;
	localparam logic [4:0][7:0] UNLOCK_ADDR = {ADDR_TERTIARY, ADDR_SECONDARY, ADDR_PRIMARY, ADDR_KEY_B, ADDR_KEY_A};
	localparam logic [4:0][7:0] UNLOCK_DATA = {TERTIARY_ON, SECONDARY_ON, PRIMARY_ON, KEY_B_VAL, KEY_A_VAL};

	// pattern fields: bit 6 odd, 5 pixels 2 mod 4, 4 pixels 4 mod 8, 3 pixels 0 mod 8
	localparam int         PAT_SEL_LSB    = 3;
	localparam int         PAT_SEL_W      = 4;

	// ***************************************************************
	// timing at 20 MHz
	// ***************************************************************
	localparam int         CLK_PERIOD_NS  = 50;
	localparam int         SETTLE_NS      = 10000;
	localparam int         SHUTTER_NS     = 20000;
	localparam int         SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         SHUTTER_CYC    = SHUTTER_NS / CLK_PERIOD_NS;
	localparam int         FLUSH_CYC      = 16;
	localparam int         SHIFT_CYC      = 32;
	localparam int         CNT_W          = 9;

	// ***************************************************************
	// types
	// ***************************************************************
	typedef struct packed {
		logic [7:0] primary;
		logic [7:0] pattern;
		logic [7:0] secondary;
		logic [7:0] tertiary;
	} fss_cfg_t;

	typedef struct packed {
		logic test_sel;
		logic region_sel;
		logic rd_dir;
		logic shutter;
	} fss_pins_t;

	localparam fss_cfg_t   CFG_RST        = '{PRIMARY_RST, PATTERN_RST, SECONDARY_RST, TERTIARY_RST};

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_FLUSH = 5'b00010,
		ST_INTEG = 5'b00100,
		ST_SHIFT = 5'b01000,
		ST_READY = 5'b10000
	} fss_state_t;

endpackage : fss_pkg

// ==== logic/fss_self_test.sv ====
// fill-and-spill self-test sequencer: pin sync, test registers, shutter sequence, injection control
`timescale 1ns/1ns
module fss_self_test (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       reg_wr_en,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wr_data,
	input  wire logic       test_select_pin,
	input  wire logic       region_select_pin,
	input  wire logic       readout_dir_pin,
	input  wire logic       shutter_pin,
	input  wire logic       diff_mode,
	input  wire logic       read_start,
	input  wire logic [1:0] analog_stimulus_pins_i,
	output logic      [1:0] analog_stimulus_pins_o,
	output logic      [1:0] analog_stimulus_pins_oe,
	output logic            test_active,
	output logic            flush_en,
	output logic            shift_en,
	output logic            inject_en,
	output logic      [3:0] inject_sel,
	output logic            frame_avail,
	output logic            region_sel,
	output logic            readout_dir,
	output logic            shutter_len_err,
	output logic            settle_err
);

	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	fss_pkg::fss_pins_t pins_raw;
	fss_pkg::fss_pins_t sync1_r;
	fss_pkg::fss_pins_t sync2_r;
	fss_pkg::fss_pins_t sync3_r;
	fss_pkg::fss_pins_t pins_r;

	assign pins_raw = '{test_select_pin, region_select_pin, readout_dir_pin, shutter_pin};

	// three stages; a level is taken once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
					sync3_r[gi] <= 1'b0;
					pins_r[gi]  <= 1'b0;
				end else begin
					sync1_r[gi] <= pins_raw[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
					if (sync2_r[gi] == sync3_r[gi]) begin
						pins_r[gi] <= sync3_r[gi];
					end
				end
			end
		end
	endgenerate

	// ***************************************************************
	// test configuration registers
	// ***************************************************************
	logic              unlocked;
	fss_pkg::fss_cfg_t cfg_r;
	fss_pkg::fss_cfg_t cfg_nxt;
	logic              wr_open;
	logic              wr_primary;
	logic              wr_pattern;
	logic              wr_secondary;
	logic              wr_tertiary;

	fss_unlock u_unlock (
		.clock    (clock),
		.rst      (rst),
		.wr_en    (reg_wr_en),
		.wr_addr  (reg_addr),
		.wr_data  (reg_wr_data),
		.unlocked (unlocked)
	);

	// the unlock sequence itself writes d2/d4/d5, so those also land while test-select is up
	assign wr_open      = unlocked | pins_r.test_sel;
	assign wr_primary   = reg_wr_en && wr_open && (reg_addr == fss_pkg::ADDR_PRIMARY);
	assign wr_pattern   = reg_wr_en && unlocked && (reg_addr == fss_pkg::ADDR_PATTERN);
	assign wr_secondary = reg_wr_en && wr_open && (reg_addr == fss_pkg::ADDR_SECONDARY);
	assign wr_tertiary  = reg_wr_en && wr_open && (reg_addr == fss_pkg::ADDR_TERTIARY);

	assign cfg_nxt.primary   = wr_primary ? reg_wr_data : cfg_r.primary;
	assign cfg_nxt.pattern   = wr_pattern ? reg_wr_data : cfg_r.pattern;
	assign cfg_nxt.secondary = wr_secondary ? reg_wr_data : cfg_r.secondary;
	assign cfg_nxt.tertiary  = wr_tertiary ? reg_wr_data : cfg_r.tertiary;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_r <= fss_pkg::CFG_RST;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// ***************************************************************
	// mode and timing checks
	// ***************************************************************
	logic                       active_nxt;
	logic                       active_r;
	logic                       shut_d_r;
	logic                       shut_rise;
	logic                       shut_fall;
	logic [fss_pkg::CNT_W-1:0]  settle_cnt_r;
	logic [fss_pkg::CNT_W-1:0]  shut_cnt_r;
	logic                       settled;
	logic                       len_bad;
	logic                       enter;

	// mode needs unlock, test-select high, differential readout and the primary, secondary and tertiary values in place;
	// writing the exit values drops it again
	assign active_nxt = unlocked && pins_r.test_sel && diff_mode && (cfg_r.primary == fss_pkg::PRIMARY_ON) &&
	                    (cfg_r.secondary == fss_pkg::SECONDARY_ON) && (cfg_r.tertiary == fss_pkg::TERTIARY_ON);
	assign shut_rise  = pins_r.shutter & ~shut_d_r;
	assign shut_fall  = ~pins_r.shutter & shut_d_r;
	assign enter      = active_nxt & ~active_r;
	assign settled    = settle_cnt_r >= fss_pkg::CNT_W'(fss_pkg::SETTLE_CYC);
	assign len_bad    = shut_cnt_r != fss_pkg::CNT_W'(fss_pkg::SHUTTER_CYC);

	// settle counts from the moment the stimulus pins turn to inputs; shutter count saturates
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			active_r     <= 1'b0;
			shut_d_r     <= 1'b0;
			settle_cnt_r <= '0;
			shut_cnt_r   <= '0;
		end else begin
			active_r     <= active_nxt;
			shut_d_r     <= pins_r.shutter;
			settle_cnt_r <= !active_r ? '0 : (settled ? settle_cnt_r : settle_cnt_r + 1'b1);
			shut_cnt_r   <= shut_rise ? 9'h001 : ((pins_r.shutter && !(&shut_cnt_r)) ? shut_cnt_r + 1'b1 : shut_cnt_r);
		end
	end

	// sticky errors: a new fault wins over the clear that comes with re-entry
	logic shut_err_nxt;
	logic settle_err_nxt;
	assign shut_err_nxt   = (active_r && shut_fall && len_bad) | (shutter_len_err & ~enter);
	assign settle_err_nxt = (active_r && shut_rise && !settled) | (settle_err & ~enter);

	// ***************************************************************
	// acquisition sequence
	// ***************************************************************
	fss_pkg::fss_state_t        state_r;
	fss_pkg::fss_state_t        state_nxt;
	logic [fss_pkg::CNT_W-1:0]  phase_cnt_r;
	logic [fss_pkg::CNT_W-1:0]  phase_cnt_nxt;
	logic                       phase_done;

	assign phase_done = phase_cnt_r == '0;

	// the same flush, integrate, shift order runs lit or stimulated
	always_comb begin
		state_nxt     = state_r;
		phase_cnt_nxt = phase_done ? phase_cnt_r : phase_cnt_r - 1'b1;
		unique case (state_r)
			fss_pkg::ST_IDLE: begin
				if (shut_rise) begin
					state_nxt     = fss_pkg::ST_FLUSH;
					phase_cnt_nxt = fss_pkg::CNT_W'(fss_pkg::FLUSH_CYC - 1);
				end
			end
			fss_pkg::ST_FLUSH: begin
				if (phase_done) begin
					state_nxt = fss_pkg::ST_INTEG;
				end
			end
			fss_pkg::ST_INTEG: begin
				if (!pins_r.shutter) begin
					state_nxt     = fss_pkg::ST_SHIFT;
					phase_cnt_nxt = fss_pkg::CNT_W'(fss_pkg::SHIFT_CYC - 1);
				end
			end
			fss_pkg::ST_SHIFT: begin
				if (phase_done) begin
					state_nxt = fss_pkg::ST_READY;
				end
			end
			fss_pkg::ST_READY: begin
				if (read_start) begin
					state_nxt = fss_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// ***************************************************************
	// registered outputs
	// ***************************************************************
	logic [3:0] sel_nxt;
	assign sel_nxt = cfg_r.pattern[fss_pkg::PAT_SEL_LSB +: fss_pkg::PAT_SEL_W];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r                 <= fss_pkg::ST_IDLE;
			phase_cnt_r             <= '0;
			test_active             <= 1'b0;
			flush_en                <= 1'b0;
			shift_en                <= 1'b0;
			inject_en               <= 1'b0;
			inject_sel              <= 4'h0;
			frame_avail             <= 1'b0;
			region_sel              <= 1'b0;
			readout_dir             <= 1'b0;
			shutter_len_err         <= 1'b0;
			settle_err              <= 1'b0;
			analog_stimulus_pins_o  <= 2'h0;
			analog_stimulus_pins_oe <= 2'h3;
		end else begin
			state_r                 <= state_nxt;
			phase_cnt_r             <= phase_cnt_nxt;
			test_active             <= active_nxt;
			flush_en                <= state_nxt == fss_pkg::ST_FLUSH;
			shift_en                <= state_nxt == fss_pkg::ST_SHIFT;
			inject_en               <= active_nxt && (state_nxt == fss_pkg::ST_INTEG);
			inject_sel              <= active_nxt ? sel_nxt : 4'h0;
			frame_avail             <= state_nxt == fss_pkg::ST_READY;
			region_sel              <= pins_r.region_sel;
			readout_dir             <= pins_r.rd_dir;
			shutter_len_err         <= shut_err_nxt;
			settle_err              <= settle_err_nxt;
			analog_stimulus_pins_o  <= 2'h0;
			analog_stimulus_pins_oe <= active_nxt ? 2'h0 : 2'h3;
		end
	end

endmodule : fss_self_test

// ==== logic/fss_unlock.sv ====
// unlock sequence tracker for the test configuration space
`timescale 1ns/1ns
module fss_unlock (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	output logic            unlocked
);

	logic [2:0] step_r;
	logic [2:0] step_nxt;
	logic       unlocked_r;
	logic       hit;
	logic       hit_first;

	// a wrong write restarts the sequence, but may itself be a fresh first key
	assign hit       = wr_en && (wr_addr == fss_pkg::UNLOCK_ADDR[step_r]) && (wr_data == fss_pkg::UNLOCK_DATA[step_r]);
	assign hit_first = wr_en && (wr_addr == fss_pkg::UNLOCK_ADDR[0]) && (wr_data == fss_pkg::UNLOCK_DATA[0]);
	assign step_nxt  = unlocked_r ? step_r : (hit ? step_r + 3'h1 : (wr_en ? {2'h0, hit_first} : step_r));
	assign unlocked  = unlocked_r;

	// unlock is sticky; only reset closes the space again
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			step_r     <= 3'h0;
			unlocked_r <= 1'b0;
		end else begin
			step_r     <= step_nxt;
			unlocked_r <= unlocked_r | (hit && (step_r == 3'(fss_pkg::UNLOCK_STEPS - 1)));
		end
	end

endmodule : fss_unlock

// ==== sim/fss_ctrl_model.sv ====
// far-side controller model for the two analog test pins
`timescale 1ns/1ns
module fss_ctrl_model (
	input  wire logic       clock,
	input  wire logic       stim_on,
	input  wire logic [1:0] pins_oe,
	output logic      [1:0] pins_drv
);
	logic [1:0] pat_r = 2'h1;
	// a released line toggles every cycle so a stale value never passes
	always_ff @(posedge clock) begin
		pat_r <= ~pat_r;
	end
	// stimulus only once the device has turned its drivers off
	assign pins_drv = (stim_on && pins_oe == 2'h0) ? 2'h3 : pat_r;
endmodule : fss_ctrl_model

// ==== sim/fss_props.sv ====
// concurrent checks on the self-test sequencer ports
`timescale 1ns/1ns
module fss_props (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       read_start,
	input  wire logic [1:0] analog_stimulus_pins_o,
	input  wire logic [1:0] analog_stimulus_pins_oe,
	input  wire logic       test_active,
	input  wire logic       flush_en,
	input  wire logic       shift_en,
	input  wire logic       inject_en,
	input  wire logic [3:0] inject_sel,
	input  wire logic       frame_avail
);
	logic [5:0] flush_cnt_r;
	logic [5:0] shift_cnt_r;
	// phase length counters, the repetition would be too long to unroll
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flush_cnt_r <= 6'h00;
			shift_cnt_r <= 6'h00;
		end else begin
			flush_cnt_r <= flush_en ? flush_cnt_r + 6'h01 : 6'h00;
			shift_cnt_r <= shift_en ? shift_cnt_r + 6'h01 : 6'h00;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// ***************************************************************
	// assertions
	// ***************************************************************
	a_pin_dir_mode: assert property (analog_stimulus_pins_oe == {2{!test_active}})
		else $error("analog pin direction does not follow test mode");
	a_pin_out_low: assert property (analog_stimulus_pins_o == 2'h0)
		else $error("analog pin output value not low");
	a_flush_length: assert property ($fell(flush_en) |-> flush_cnt_r == 6'h10)
		else $error("flush phase length wrong");
	a_shift_length: assert property ($fell(shift_en) |-> shift_cnt_r == 6'h20)
		else $error("shift phase length wrong");
	a_flush_then_inject: assert property ($fell(flush_en) && test_active |-> ##[0:1] (inject_en || shift_en))
		else $error("no injection after flush");
	a_shift_then_avail: assert property ($fell(shift_en) |-> ##[0:1] frame_avail)
		else $error("frame flag missing after shift");
	a_avail_holds: assert property (frame_avail && !read_start |=> frame_avail)
		else $error("frame flag dropped without readout");
	a_inject_in_test: assert property (inject_en |-> test_active && !flush_en && !shift_en)
		else $error("injection outside integrate phase of test");
	a_sel_idle_zero: assert property (!test_active |-> inject_sel == 4'h0)
		else $error("pattern select active outside test");
	c_frame_done: cover property ($rose(frame_avail));
	c_inject_run: cover property ($rose(inject_en));
	c_mode_exit: cover property ($fell(test_active));
endmodule : fss_props

bind fss_self_test fss_props fss_props_inst (.clock(clock), .rst(rst), .read_start(read_start),
	.analog_stimulus_pins_o(analog_stimulus_pins_o), .analog_stimulus_pins_oe(analog_stimulus_pins_oe),
	.test_active(test_active), .flush_en(flush_en), .shift_en(shift_en), .inject_en(inject_en),
	.inject_sel(inject_sel), .frame_avail(frame_avail));

// ==== sim/tb_fss_self_test.sv ====
// testbench for the fill-and-spill self-test sequencer
`timescale 1ns/1ns
module tb_fss_self_test;
	logic       clock, rst, reg_wr_en, test_select_pin, region_select_pin, readout_dir_pin;
	logic       shutter_pin, diff_mode, read_start, stim_on, test_active, flush_en, shift_en;
	logic       inject_en, frame_avail, region_sel, readout_dir, len_err, set_err;
	logic [7:0] reg_addr, reg_wr_data;
	logic [1:0] ana_o, ana_oe, ana_drv, ana_wire;
	logic [3:0] inject_sel;
	int         num_errors = 0;
	int         cmp_count  = 0;
	// resolved pin level from the device's enables alone
	assign ana_wire = (ana_oe & ana_o) | (~ana_oe & ana_drv);
	fss_self_test fss_self_test_inst (.clock(clock), .rst(rst), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .test_select_pin(test_select_pin), .region_select_pin(region_select_pin),
		.readout_dir_pin(readout_dir_pin), .shutter_pin(shutter_pin), .diff_mode(diff_mode),
		.read_start(read_start), .analog_stimulus_pins_i(ana_wire), .analog_stimulus_pins_o(ana_o),
		.analog_stimulus_pins_oe(ana_oe), .test_active(test_active), .flush_en(flush_en), .shift_en(shift_en),
		.inject_en(inject_en), .inject_sel(inject_sel), .frame_avail(frame_avail), .region_sel(region_sel),
		.readout_dir(readout_dir), .shutter_len_err(len_err), .settle_err(set_err));
	fss_ctrl_model fss_ctrl_model_inst (.clock(clock), .stim_on(stim_on), .pins_oe(ana_oe), .pins_drv(ana_drv));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic step(int n = 1);
		repeat (n) @(posedge clock);
		#5;
	endtask : step
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wr_data = d;
		step();
		reg_wr_en = 1'b0;
		step();
	endtask : wr
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	// one shutter pulse of len cycles, then readout of the frame
	task automatic frame(int len, logic [3:0] sel);
		logic saw_flush, saw_shift;
		saw_flush = 1'b0;
		saw_shift = 1'b0;
		shutter_pin = 1'b1;
		for (int n = 0; n < len; n++) begin
			step();
			saw_flush |= (flush_en === 1'b1);
			if (n == 100) chk("inject_en", 8'h01, inject_en);
			if (n == 100) chk("inject_sel", sel, inject_sel);
		end
		shutter_pin = 1'b0;
		for (int n = 0; n < 100 && frame_avail !== 1'b1; n++) begin
			step();
			saw_shift |= (shift_en === 1'b1);
		end
		chk("flush seen", 8'h01, saw_flush);
		chk("shift seen", 8'h01, saw_shift);
		chk("frame_avail", 8'h01, frame_avail);
		read_start = 1'b1;
		step();
		read_start = 1'b0;
		step(2);
		chk("frame_avail cleared", 8'h00, frame_avail);
	endtask : frame
	task automatic t_bad_unlock();
		diff_mode = 1'b1;
		test_select_pin = 1'b1;
		step(6);
		wr(8'hD0, 8'h4A);
		wr(8'hD1, 8'h65);
		wr(8'hD2, 8'h02);
		wr(8'hD4, 8'h20);
		wr(8'hD5, 8'h21);
		step(4);
		chk("test_active bad key", 8'h00, test_active);
		$display("test bad_unlock done");
	endtask : t_bad_unlock
	task automatic t_entry_frame();
		region_select_pin = 1'b1;
		for (int i = 0; i < 5; i++) wr(fss_pkg::UNLOCK_ADDR[i], fss_pkg::UNLOCK_DATA[i]);
		step(4);
		chk("test_active", 8'h01, test_active);
		chk("pins_oe in test", 8'h00, ana_oe);
		chk("region_sel", 8'h01, region_sel);
		chk("readout_dir", 8'h00, readout_dir);
		wr(8'hD3, 8'h79);
		stim_on = 1'b1;
		step(220);
		frame(400, 4'hF);
		chk("shutter_len_err", 8'h00, len_err);
		chk("settle_err", 8'h00, set_err);
		$display("test entry_frame done");
	endtask : t_entry_frame
	task automatic t_patterns();
		for (int i = 0; i < 4; i++) begin
			wr(8'hD3, {1'b0, 4'(1 << i), 3'b001});
			frame(400, 4'(1 << i));
		end
		frame(399, 4'h8);
		chk("shutter_len_err short", 8'h01, len_err);
		$display("test patterns done");
	endtask : t_patterns
	task automatic t_exit_reenter();
		stim_on = 1'b0;
		wr(8'hD4, 8'h00);
		wr(8'hD5, 8'h01);
		wr(8'hD2, 8'h00);
		wr(8'hD3, 8'h00);
		test_select_pin = 1'b0;
		region_select_pin = 1'b0;
		readout_dir_pin = 1'b1;
		step(6);
		chk("test_active exit", 8'h00, test_active);
		chk("pins_oe exit", 8'h03, ana_oe);
		chk("region_sel exit", 8'h00, region_sel);
		chk("readout_dir exit", 8'h01, readout_dir);
		test_select_pin = 1'b1;
		step(6);
		wr(8'hD2, 8'h02);
		wr(8'hD4, 8'h20);
		wr(8'hD5, 8'h21);
		wr(8'hD3, 8'h09);
		step(2);
		chk("test_active relock", 8'h01, test_active);
		frame(400, 4'h1);
		chk("settle_err early", 8'h01, set_err);
		chk("len_err cleared", 8'h00, len_err);
		$display("test exit_reenter done");
	endtask : t_exit_reenter
	task automatic t_reset_lock();
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		step();
		chk("pins_oe reset", 8'h03, ana_oe);
		// let test-select pass the synchroniser so only the lock can refuse the mode
		step(4);
		wr(8'hD2, 8'h02);
		wr(8'hD4, 8'h20);
		wr(8'hD5, 8'h21);
		step(4);
		chk("test_active locked", 8'h00, test_active);
		// single-ended readout keeps the mode shut even after a full unlock
		diff_mode = 1'b0;
		for (int i = 0; i < 5; i++) wr(fss_pkg::UNLOCK_ADDR[i], fss_pkg::UNLOCK_DATA[i]);
		step(4);
		chk("test_active single-ended", 8'h00, test_active);
		diff_mode = 1'b1;
		step(2);
		chk("test_active differential", 8'h01, test_active);
		$display("test reset_lock done");
	endtask : t_reset_lock
	initial begin
		{rst, reg_wr_en, test_select_pin, region_select_pin, readout_dir_pin} = 5'h10;
		{shutter_pin, diff_mode, read_start, stim_on, reg_addr, reg_wr_data} = '0;
		step(8);
		rst = 1'b0;
		step();
		chk("pins_oe after reset", 8'h03, ana_oe);
		chk("test_active after reset", 8'h00, test_active);
		t_bad_unlock();
		t_entry_frame();
		t_patterns();
		t_exit_reenter();
		t_reset_lock();
		end_of_test();
	end
	// watchdog well beyond the seven frames of the run
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		$display("[ERR] watchdog expected done seen hang");
		end_of_test();
	end
endmodule : tb_fss_self_test
